// *** bench/serial_sink.sv ***
// Serial receiver model: takes bytes with random stalls and keeps them in order
module serial_sink (
    input  wire logic       mclk,
    input  wire logic       stall,
    input  wire logic       tx_valid,
    input  wire logic [7:0] tx_data,
    output logic            tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    logic [3:0] lfsr = 4'h9;
    initial tx_ready = 1'b0;
    // Ready moves only after the falling edge, never in mid-handshake sampling
    always @(negedge mclk)
    begin
        lfsr = {lfsr[2:0], lfsr[3] ^ lfsr[2]};
        tx_ready = !stall && lfsr[0];
    end
    // Whole 8-bit characters are taken in arrival order
    always @(posedge mclk)
    begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1)
        begin
            rx_q.push_back(tx_data);
        end
    end
endmodule : serial_sink

// *** bench/tb_top.sv ***
// Self-checking bench: sentence model compared byte by byte with the encoder
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                             mclk = 1'b0;
    logic                             srst = 1'b1;
    logic                             sleep_mode = 1'b0;
    logic [15:0]                      active_period_ms = 16'h0000;
    logic [15:0]                      sleep_period_ms = 16'h0000;
    logic                             summary_request = 1'b0;
    logic                             detail_request = 1'b0;
    logic                             modules_ok = 1'b1;
    balancing_sentence_pkg::summary_s summary = '0;
    logic [15:0]                      cells_per_string = 16'h0000;
    logic [15:0]                      cell_addr;
    logic [7:0]                       cell_rate;
    logic                             tx_valid;
    logic                             tx_ready;
    logic [7:0]                       tx_data;
    logic                             busy;
    logic                             stall = 1'b0;
    logic [7:0]                       rate_tab[64];
    logic [7:0]                       sq[$];
    logic [7:0]                       exp_q[$];
    logic [31:0]                      seed = 32'h0001_4A03;
    int                               error_cnt = 0;
    int                               checks = 0;

    assign cell_rate = rate_tab[cell_addr[5:0]];

    balancing_sentence_encoder #(.MS_CYCLES(10)) i_dut (.mclk(mclk), .srst(srst),
        .sleep_mode(sleep_mode), .active_period_ms(active_period_ms),
        .sleep_period_ms(sleep_period_ms), .summary_request(summary_request),
        .detail_request(detail_request), .modules_ok(modules_ok), .summary(summary),
        .cells_per_string(cells_per_string), .cell_addr(cell_addr), .cell_rate(cell_rate),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .busy(busy));

    serial_sink i_sink (.mclk(mclk), .stall(stall), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready));

    initial forever #5 mclk = ~mclk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic end_sim();
        if (error_cnt == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_sim

    task automatic cmp(input string what, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    // Uppercase digits, most significant nibble first, then a comma
    task automatic put_f(input logic [15:0] v, input int n);
        for (int i = n - 1; i >= 0; i--)
            sq.push_back((v[i*4 +: 4] < 4'hA) ? 8'h30 + v[i*4 +: 4] : 8'h37 + v[i*4 +: 4]);
        sq.push_back(8'h2C);
    endtask : put_f

    // Reflected CRC from zero over the sentence, then two digits and CR LF
    task automatic seal();
        logic [7:0] crc;
        logic [7:0] d;
        crc = 8'h00;
        foreach (sq[i])
        begin
            d = sq[i];
            for (int b = 0; b < 8; b++)
            begin
                crc = (crc[0] ^ d[0]) ? (((crc ^ 8'h18) >> 1) | 8'h80) : (crc >> 1);
                d = d >> 1;
            end
        end
        put_f(16'(crc), 2);
        void'(sq.pop_back());
        exp_q = {exp_q, sq, 8'h0D, 8'h0A};
    endtask : seal

    task automatic sum_exp();
        sq = {8'h42, 8'h42, 8'h31, 8'h2C};
        if (modules_ok && summary.cells != 16'h0000)
        begin
            put_f(summary.cells, 4);
            put_f(16'(summary.rate_min), 2);
            put_f(16'(summary.rate_max), 2);
            put_f(16'(summary.rate_avg), 2);
            sq.push_back(8'h2C);
            put_f(16'(summary.threshold), 2);
        end
        else
            sq = {sq, 8'h2C, 8'h2C, 8'h2C, 8'h2C, 8'h2C, 8'h2C};
        seal();
    endtask : sum_exp

    task automatic det_exp();
        int c;
        int p;
        int first;
        int size;
        c = int'(summary.cells);
        p = int'(cells_per_string);
        first = 0;
        if (!modules_ok || c == 0)
        begin
            sq = {8'h42, 8'h42, 8'h32, 8'h2C, 8'h2C, 8'h2C, 8'h2C, 8'h2C};
            seal();
        end
        while (modules_ok && first < c)
        begin
            size = (c - first < 8) ? c - first : 8;
            if (p != 0 && p - first % p < size)
                size = p - first % p;
            sq = {8'h42, 8'h42, 8'h32, 8'h2C};
            put_f(16'((p != 0) ? first / p : 0), 2);
            put_f(16'(first), 4);
            put_f(16'(size), 2);
            for (int k = 0; k < size; k++)
            begin
                put_f(16'(rate_tab[(first + k) % 64]), 2);
                void'(sq.pop_back());
            end
            sq.push_back(8'h2C);
            seal();
            first += size;
        end
    endtask : det_exp

    task automatic collect();
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 20000)
        begin
            @(negedge mclk);
            n++;
            while (i_sink.rx_q.size() != 0 && exp_q.size() != 0)
                cmp("tx byte", 16'(exp_q.pop_front()), 16'(i_sink.rx_q.pop_front()));
        end
        if (exp_q.size() != 0)
        begin
            cmp("bytes left", 16'h0000, 16'(exp_q.size()));
            end_sim();
        end
    endtask : collect

    task automatic periodic(input logic slp, input int lim);
        int n;
        n = 0;
        sum_exp();
        sleep_mode = slp;
        active_period_ms = slp ? 16'h0028 : 16'h0003;
        sleep_period_ms = 16'h0002;
        while (busy !== 1'b1 && n < lim)
        begin
            @(negedge mclk);
            n++;
        end
        cmp("busy", 16'h0001, 16'(busy));
        active_period_ms = 16'h0000;
        sleep_period_ms = 16'h0000;
        collect();
    endtask : periodic

    initial
    begin
        foreach (rate_tab[i])
            rate_tab[i] = 8'(xs());
        repeat (6) @(negedge mclk);
        srst = 1'b0;
        for (int r = 0; r < 3; r++)
        begin
            summary = (r == 1) ? 48'hFFFF_FF00_ABFF : 48'({xs(), xs()});
            modules_ok = (r != 2);
            sum_exp();
            summary_request = 1'b1;
            @(negedge mclk);
            summary_request = 1'b0;
            collect();
        end
        for (int r = 0; r < 3; r++)
        begin
            summary.cells = (r == 0) ? 16'h0014 : 16'h0009;
            cells_per_string = (r == 0) ? 16'h000C : 16'h0000;
            modules_ok = (r != 2);
            det_exp();
            if (r == 0)
                sum_exp();
            stall = 1'b1;
            detail_request = 1'b1;
            summary_request = (r == 0);
            @(negedge mclk);
            detail_request = 1'b0;
            summary_request = 1'b0;
            repeat (100) @(negedge mclk);
            stall = 1'b0;
            collect();
        end
        periodic(1'b0, 45);
        periodic(1'b1, 35);
        repeat (500) @(negedge mclk);
        cmp("quiet bytes", 16'h0000, 16'(i_sink.rx_q.size()));
        end_sim();
    end
endmodule : tb_top

// *** hw/balancing_sentence_encoder.sv ***
// Balancing summary and detail sentence encoder with its output FIFO
// Overview of operation
// - Hex digits are 0-9 and uppercase A-F
// - Hex values go most significant nibble first
// - Hex widths: 2 and 4 characters
// - Byte arrays are unseparated two-character hex bytes
// - Flag bytes go as two hex characters
// - Decimal fields are plain base-ten strings
// - New fields only ever follow existing ones
// - Summary repeats with active or sleep period
// - Summary also sent on request
// - Unreachable modules give empty fields, valid CRC
// - Summary field one is cell count
// - Fields two to four: min, max, average
// - Summary field five always empty
// - Field six is balancing threshold
// - Detail sentences only on request
// - Each detail group holds one to eight cells
// - Detail field one is string index
// - Detail field two is global first cell
// - Detail field four is per-cell rate bytes
// - CRC-8 reflected, constant 0x18, zero start
// - Name, fields, CRC, then CR LF
// - Link is 57.6 kbit/s, 8N1
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             mclk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;
    assign in_ready  = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    always_ff @(posedge mclk)
    begin
        if (push)
            mem[wr_ptr] <= in_data;
    end
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end
        else
        begin
            if (push)
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            if (pop)
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : byte_fifo

module balancing_sentence_encoder #(
    parameter int MS_CYCLES = balancing_sentence_pkg::MS_CYCLES
) (
    input  wire logic                             mclk,
    input  wire logic                             srst,
    input  wire logic                             sleep_mode,
    input  wire logic [15:0]                      active_period_ms,
    input  wire logic [15:0]                      sleep_period_ms,
    input  wire logic                             summary_request,
    input  wire logic                             detail_request,
    input  wire logic                             modules_ok,
    input  wire balancing_sentence_pkg::summary_s summary,
    input  wire logic [15:0]                      cells_per_string,
    output logic      [15:0]                      cell_addr,
    input  wire logic [7:0]                       cell_rate,
    output logic                                  tx_valid,
    input  wire logic                             tx_ready,
    output logic      [7:0]                       tx_data,
    output logic                                  busy
);
    balancing_sentence_pkg::state_e   state;
    balancing_sentence_pkg::summary_s snap;
    logic        detail, empty, xfer, in_ready, sum_pending, det_pending;
    logic        det_active, start_sum, start_new, start_cont, starting, done;
    logic [2:0]  fld, nf, last_fld;
    logic [1:0]  pos_name;
    logic [4:0]  pos, nib_left, ld_nib;
    logic [15:0] val, ld_val, grp_first, in_str, rem_str, rem_all, ms_cnt, period;
    logic [7:0]  crc, byte_out, grp_str;
    logic [3:0]  grp_size, next_size;
    logic [31:0] pre;
    logic        tick, fire;

    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < balancing_sentence_pkg::NIB_TEN)
                 ? balancing_sentence_pkg::CH_ZERO + 8'(n)
                 : balancing_sentence_pkg::CH_HEX_A + 8'(n);
    endfunction : hex_char

    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
        logic fb;
        crc8 = c;
        for (int i = 0; i < 8; i++)
        begin
            fb = crc8[0] ^ d[i];
            if (fb)
                crc8 = crc8 ^ balancing_sentence_pkg::CRC_POLY;
            crc8 = {fb, crc8[7:1]};
        end
    endfunction : crc8

    // Millisecond timebase and periodic summary trigger
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            pre    <= '0;
            ms_cnt <= '0;
        end
        else
        begin
            pre <= tick ? '0 : pre + 1;
            if (period == '0)
                ms_cnt <= '0;
            else if (fire)
                ms_cnt <= '0;
            else if (tick)
                ms_cnt <= ms_cnt + 16'h0001;
        end
    end
    assign tick   = pre == 32'(MS_CYCLES - 1);
    assign period = sleep_mode ? sleep_period_ms : active_period_ms;
    assign fire   = tick && period != '0 && ms_cnt >= period - 16'h0001;

    // Pending requests; a new request in the start cycle is kept
    assign starting   = state == balancing_sentence_pkg::ST_IDLE;
    assign start_cont = starting && det_active;
    assign start_new  = starting && !det_active && det_pending;
    assign start_sum  = starting && !det_active && !det_pending && sum_pending;
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            sum_pending <= 1'b0;
            det_pending <= 1'b0;
        end
        else
        begin
            sum_pending <= (sum_pending && !start_sum) || summary_request || fire;
            det_pending <= (det_pending && !start_new) || detail_request;
        end
    end

    // Detail grouping: ascending cells, split at string ends and at eight
    assign rem_all = snap.cells - grp_first;
    assign rem_str = (cells_per_string == '0) ? rem_all : cells_per_string - in_str;
    always_comb
    begin
        next_size = balancing_sentence_pkg::GROUP_MAX;
        if (rem_str < 16'(next_size))
            next_size = rem_str[3:0];
        if (rem_all < 16'(next_size))
            next_size = rem_all[3:0];
    end
    assign done = xfer && state == balancing_sentence_pkg::ST_EOL && pos[0];
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            det_active <= 1'b0;
            grp_first  <= '0;
            in_str     <= '0;
            grp_str    <= '0;
            grp_size   <= '0;
            snap       <= '0;
        end
        else if (start_new || start_sum)
        begin
            det_active <= start_new && modules_ok && summary.cells != '0;
            grp_first  <= '0;
            in_str     <= '0;
            grp_str    <= '0;
            grp_size   <= '0;
            snap       <= summary;
        end
        else if (start_cont)
            grp_size <= next_size;
        else if (done && detail && !empty)
        begin
            grp_first  <= grp_first + 16'(grp_size);
            det_active <= grp_first + 16'(grp_size) < snap.cells;
            if (cells_per_string != '0 && in_str + 16'(grp_size) == cells_per_string)
            begin
                in_str  <= '0;
                grp_str <= grp_str + 8'h01;
            end
            else
                in_str <= in_str + 16'(grp_size);
        end
    end

    // Field loader; fields never reorder, later ones only append
    assign last_fld = detail ? balancing_sentence_pkg::DET_FIELDS
                             : balancing_sentence_pkg::SUM_FIELDS;
    assign nf = (state == balancing_sentence_pkg::ST_NAME) ? balancing_sentence_pkg::F_CELLS
                                                           : fld + 3'h1;
    always_comb
    begin
        ld_val = '0;
        ld_nib = balancing_sentence_pkg::NIB_NONE;
        if (!empty && detail)
        begin
            unique case (nf)
                balancing_sentence_pkg::F_CELLS:
                begin
                    ld_val = {grp_str, 8'h00};
                    ld_nib = balancing_sentence_pkg::NIB_BYTE;
                end
                balancing_sentence_pkg::F_MIN:
                begin
                    ld_val = grp_first;
                    ld_nib = balancing_sentence_pkg::NIB_WORD;
                end
                balancing_sentence_pkg::F_MAX:
                begin
                    ld_val = {4'h0, grp_size, 8'h00};
                    ld_nib = balancing_sentence_pkg::NIB_BYTE;
                end
                default:
                    ld_nib = {grp_size, 1'b0};
            endcase
        end
        else if (!empty)
        begin
            unique case (nf)
                balancing_sentence_pkg::F_CELLS:
                begin
                    ld_val = snap.cells;
                    ld_nib = balancing_sentence_pkg::NIB_WORD;
                end
                balancing_sentence_pkg::F_MIN: ld_val = {snap.rate_min, 8'h00};
                balancing_sentence_pkg::F_MAX: ld_val = {snap.rate_max, 8'h00};
                balancing_sentence_pkg::F_AVG: ld_val = {snap.rate_avg, 8'h00};
                balancing_sentence_pkg::F_THR: ld_val = {snap.threshold, 8'h00};
                default: ld_val = '0;
            endcase
            if (nf != balancing_sentence_pkg::F_THR - 3'h1)
                ld_nib = (nf == balancing_sentence_pkg::F_CELLS) ? balancing_sentence_pkg::NIB_WORD
                                                                 : balancing_sentence_pkg::NIB_BYTE;
        end
    end

    // Character source
    assign pos_name = pos[1:0];
    always_comb
    begin
        byte_out = balancing_sentence_pkg::CH_COMMA;
        unique case (state)
            balancing_sentence_pkg::ST_NAME:
                if (pos_name == 2'h2)
                    byte_out = detail ? balancing_sentence_pkg::CH_TWO
                                      : balancing_sentence_pkg::CH_ONE;
                else if (pos_name != balancing_sentence_pkg::NAME_LAST)
                    byte_out = balancing_sentence_pkg::CH_B;
            balancing_sentence_pkg::ST_HEX:
                if (detail && fld == balancing_sentence_pkg::F_ARRAY)
                    byte_out = hex_char(pos[0] ? cell_rate[3:0] : cell_rate[7:4]);
                else
                    byte_out = hex_char(val[15:12]);
            balancing_sentence_pkg::ST_CRC:
                byte_out = hex_char(pos[0] ? crc[3:0] : crc[7:4]);
            balancing_sentence_pkg::ST_EOL:
                byte_out = pos[0] ? balancing_sentence_pkg::CH_LF
                                  : balancing_sentence_pkg::CH_CR;
            default:
                byte_out = balancing_sentence_pkg::CH_COMMA;
        endcase
    end
    assign xfer = !starting && in_ready;
    assign busy = !starting;

    // Checksum over name, fields and commas, not over CR LF
    always_ff @(posedge mclk)
    begin
        if (srst || starting)
            crc <= balancing_sentence_pkg::CRC_INIT;
        else if (xfer && state != balancing_sentence_pkg::ST_CRC
                 && state != balancing_sentence_pkg::ST_EOL)
            crc <= crc8(crc, byte_out);
    end

    // Sentence sequencer
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            state     <= balancing_sentence_pkg::ST_IDLE;
            detail    <= 1'b0;
            empty     <= 1'b0;
            fld       <= '0;
            pos       <= '0;
            nib_left  <= '0;
            val       <= '0;
            cell_addr <= '0;
        end
        else if (starting)
        begin
            // A filled detail sequence opens one cycle later, once its group size is set
            if (start_sum || start_cont || (start_new && (!modules_ok || summary.cells == '0)))
            begin
                state  <= balancing_sentence_pkg::ST_NAME;
                detail <= !start_sum;
                empty  <= start_cont ? 1'b0 : !modules_ok || summary.cells == '0;
                pos    <= '0;
                fld    <= '0;
                cell_addr <= grp_first;
            end
        end
        else if (xfer)
        begin
            pos <= pos + 5'h01;
            unique case (state)
                balancing_sentence_pkg::ST_NAME, balancing_sentence_pkg::ST_COMMA:
                    if (state == balancing_sentence_pkg::ST_COMMA && fld == last_fld)
                    begin
                        state <= balancing_sentence_pkg::ST_CRC;
                        pos   <= '0;
                    end
                    else if (state == balancing_sentence_pkg::ST_COMMA
                             || pos_name == balancing_sentence_pkg::NAME_LAST)
                    begin
                        fld      <= nf;
                        val      <= ld_val;
                        nib_left <= ld_nib;
                        pos      <= '0;
                        state    <= (ld_nib == '0) ? balancing_sentence_pkg::ST_COMMA
                                                   : balancing_sentence_pkg::ST_HEX;
                    end
                balancing_sentence_pkg::ST_HEX:
                begin
                    val      <= {val[11:0], 4'h0};
                    nib_left <= nib_left - 5'h01;
                    if (detail && fld == balancing_sentence_pkg::F_ARRAY && pos[0])
                        cell_addr <= cell_addr + 16'h0001;
                    if (nib_left == 5'h01)
                        state <= balancing_sentence_pkg::ST_COMMA;
                end
                balancing_sentence_pkg::ST_CRC:
                    if (pos[0])
                    begin
                        state <= balancing_sentence_pkg::ST_EOL;
                        pos   <= '0;
                    end
                default:
                    if (pos[0])
                        state <= balancing_sentence_pkg::ST_IDLE;
            endcase
        end
    end

    // Eight-byte FIFO towards the serial transmitter (57.6 kbit/s 8N1)
    byte_fifo #(
        .WIDTH (8),
        .DEPTH (balancing_sentence_pkg::FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .srst      (srst),
        .in_valid  (!starting),
        .in_ready  (in_ready),
        .in_data   (byte_out),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    default clocking dc @(posedge mclk); endclocking
    default disable iff (srst);
    a_hex_digit_set: assert property (xfer && state == balancing_sentence_pkg::ST_HEX |->
        (byte_out inside {[8'h30:8'h39]} || byte_out inside {[8'h41:8'h46]}))
        else $error("hex character out of range");
    a_msn_first: assert property (xfer && state == balancing_sentence_pkg::ST_HEX
        && !(detail && fld == balancing_sentence_pkg::F_ARRAY) |=> val[15:12] == $past(val[11:8]))
        else $error("nibble order broken");
    a_cell_width: assert property (xfer && state == balancing_sentence_pkg::ST_NAME
        && pos_name == balancing_sentence_pkg::NAME_LAST && !detail && !empty |=> nib_left == 5'h04)
        else $error("cell count not four characters");
    a_empty_fields: assert property (empty |-> state != balancing_sentence_pkg::ST_HEX)
        else $error("data emitted while modules unreachable");
    a_fifth_empty: assert property (!detail && fld == 3'h5 |-> state != balancing_sentence_pkg::ST_HEX)
        else $error("fifth summary field not empty");
    a_group_range: assert property (detail && !empty && state == balancing_sentence_pkg::ST_HEX
        |-> grp_size >= 4'h1 && grp_size <= 4'h8)
        else $error("group size out of range");
    a_crlf_end: assert property (xfer && state == balancing_sentence_pkg::ST_CRC && pos[0]
        |=> state == balancing_sentence_pkg::ST_EOL && byte_out == 8'h0D)
        else $error("sentence not ended by CR");
    a_detail_request: assert property ($rose(det_active) |-> $past(det_pending))
        else $error("detail sent without request");
    c_summary_done: cover property (done && !detail && !empty);
    c_detail_done: cover property (done && detail && !det_active);
    c_empty_sentence: cover property (done && empty);
    c_fifo_full: cover property (!starting && !in_ready);
endmodule : balancing_sentence_encoder

// *** hw/balancing_sentence_pkg.sv ***
// Constants, types and states of the balancing sentence encoder
package balancing_sentence_pkg;
    localparam logic [7:0] CH_B      = 8'h42;
    localparam logic [7:0] CH_ONE    = 8'h31;
    localparam logic [7:0] CH_TWO    = 8'h32;
    localparam logic [7:0] CH_COMMA  = 8'h2C;
    localparam logic [7:0] CH_CR     = 8'h0D;
    localparam logic [7:0] CH_LF     = 8'h0A;
    localparam logic [7:0] CH_ZERO   = 8'h30;
    localparam logic [7:0] CH_HEX_A  = 8'h37;
    localparam logic [3:0] NIB_TEN   = 4'hA;
    localparam logic [7:0] CRC_INIT  = 8'h00;
    localparam logic [7:0] CRC_POLY  = 8'h18;
    localparam logic [2:0] SUM_FIELDS = 3'h6;
    localparam logic [2:0] DET_FIELDS = 3'h4;
    localparam logic [2:0] F_CELLS   = 3'h1;
    localparam logic [2:0] F_MIN     = 3'h2;
    localparam logic [2:0] F_MAX     = 3'h3;
    localparam logic [2:0] F_AVG     = 3'h4;
    localparam logic [2:0] F_THR     = 3'h6;
    localparam logic [2:0] F_ARRAY   = 3'h4;
    localparam logic [4:0] NIB_BYTE  = 5'h02;
    localparam logic [4:0] NIB_WORD  = 5'h04;
    localparam logic [4:0] NIB_NONE  = 5'h00;
    localparam logic [1:0] NAME_LAST = 2'h3;
    localparam logic [3:0] GROUP_MAX = 4'h8;
    localparam int         FIFO_DEPTH = 8;
    localparam int         MS_NS     = 1000000;
    localparam int         CLK_NS    = 10;
    localparam int         MS_CYCLES = MS_NS / CLK_NS;
    typedef struct packed {
        logic [15:0] cells;
        logic [7:0]  rate_min;
        logic [7:0]  rate_max;
        logic [7:0]  rate_avg;
        logic [7:0]  threshold;
    } summary_s;
    typedef enum logic [5:0] {
        ST_IDLE  = 6'b00_0001,
        ST_NAME  = 6'b00_0010,
        ST_HEX   = 6'b00_0100,
        ST_COMMA = 6'b00_1000,
        ST_CRC   = 6'b01_0000,
        ST_EOL   = 6'b10_0000
    } state_e;
endpackage : balancing_sentence_pkg
